// *** pkg/rdmah_defs.svh ***
/*
 constants for the saturating rounding doubling multiply-add/subtract high-half datapath.
 assumes: included by bare name from the package and the design module.
*/
`ifndef RDMAH_DEFS_SVH
`define RDMAH_DEFS_SVH

// ============================================================
// element size codes and widths
`define SIZE_H          2'h1
`define SIZE_S          2'h2
`define ESIZE_BASE      8
`define VEC_WIDE_BITS   128
`define VEC_NARROW_BITS 64
`define MAX_LANES       8
`define REG_BITS        128
`define REG_IDX_BITS    5

// ============================================================
// fixed opcode fields (bits 15:10 with the subtract bit masked)
`define OPC_VEC_FIXED   6'h21
`define OPC_ELEM_FIXED  4'hd
`define OPC_ELEM_MASK   4'hd

// ============================================================
// latency
`define PIPE_CYCLES     1

`endif

// *** pkg/rdmah_pkg.sv ***
/*
 types for the saturating rounding doubling multiply-add/subtract high-half datapath.
 assumes: rdmah_defs.svh on the include path.
*/
`include "rdmah_defs.svh"

package rdmah_pkg;

    // ============================================================
    // operand form
    typedef enum logic [1:0]
    {
        FORM_VEC_VEC  = 2'h0,
        FORM_VEC_ELEM = 2'h1,
        FORM_SCL_VEC  = 2'h2,
        FORM_SCL_ELEM = 2'h3
    } form_t;

    // ============================================================
    // issued instruction as decoded fields
    typedef struct packed
    {
        logic        valid;
        form_t       form;
        logic        wide;
        logic [1:0]  size;
        logic        subtract_operation;
        logic        idx_hi;
        logic        idx_lo;
        logic        idx_mid;
        logic [5:0]  opc;
        logic [4:0]  first_source_reg;
        logic [3:0]  second_source_reg;
        logic [4:0]  dest_reg;
    } issue_t;

    // ============================================================
    // operand values read by the register file
    typedef struct packed
    {
        logic [127:0] first_src;
        logic [127:0] second_src;
        logic [127:0] dest_src;
    } operands_t;

    // ============================================================
    // access enables
    typedef struct packed
    {
        logic os_simd_access_control;
        logic hyp_simd_trap_control;
        logic secure_monitor_trap_control;
    } access_t;

    // ============================================================
    // writeback result
    typedef struct packed
    {
        logic         done;
        logic         trap;
        logic         undef;
        logic [4:0]   dest_reg;
        logic [127:0] data;
    } result_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_DONE = 2'b10
    } state_t;

    typedef struct packed
    {
        state_t  state;
        result_t res;
        logic    sat_flag;
    } core_state_t;

endpackage

// *** rtl/sat_round_dbl_mac_high_half.sv ***
/*
 saturating rounding doubling multiply-accumulate / multiply-subtract, high half.
 vector-by-vector, by-element and scalar forms; one result per issue, one cycle later.
 assumes: decode hands over field values and register-file operands in the same cycle,
 all on clk; second_source_reg_num is what the register file must read for operand two.
 limitation: one issue per cycle at most, and there is no stall input.
*/
`timescale 1ns/1ns
`include "rdmah_defs.svh"

// Summary of operation
// - element width is eight shifted left by the size code: 16 or 32 bits
// - size codes 00 and 11 are reserved and not executed
// - vector forms use 128 bits when width bit set, else 64
// - only 4H, 8H, 2S and 4S arrangements exist
// - scalar forms compute a single lane of element width
// - rounding constant one shifted by element width minus one is added
// - accumulate is dest shifted up plus twice product plus rounding
// - subtract bit set subtracts the doubled product instead
// - shift right by element width, saturate signed, store in lane
// - any saturated lane sets the sticky flag; only sat_flag_clear or reset clears it
// - multiply and doubling are full precision, only final result saturates
// - by-element index is H:L:M for 16-bit, H:L for 32-bit lanes
// - 16-bit by-element forces register top bit zero; 32-bit uses M
// - indexed source read as 128 bits when H set, else 64
// - by-element uses one selected element for all lanes
// - vector-by-vector multiplies matching lanes
// - dest lanes feed the accumulator and are overwritten by results
// - disabled simd access traps the instruction instead of executing

module sat_round_dbl_mac_high_half
    import rdmah_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire issue_t     issue,
    input  wire operands_t  ops,
    input  wire access_t    access,
    input  wire logic       rounding_mac_ext_present,
    input  wire logic       sat_flag_clear,
    output logic [4:0]      second_source_reg_num,
    output result_t         result,
    output logic            cumulative_saturation_flag
);

    // ============================================================
    // decode
    logic        is_elem;
    logic        is_scalar;
    logic        size_ok;
    logic        opc_ok;
    logic        enabled;
    logic        is_h;
    logic [5:0]  esize;
    logic [2:0]  index;
    logic [4:0]  m_reg;
    logic        m_hi;
    logic [127:0] op2_view;
    logic [3:0]  lanes_h;
    logic [2:0]  lanes_s;

    always_comb
    begin
        is_elem   = issue.form == FORM_VEC_ELEM || issue.form == FORM_SCL_ELEM;
        is_scalar = issue.form == FORM_SCL_VEC || issue.form == FORM_SCL_ELEM;
        size_ok   = issue.size == `SIZE_H || issue.size == `SIZE_S;
        esize     = 6'(`ESIZE_BASE << issue.size);
        // reserved codes land on other widths here; size_ok keeps them from running
        is_h      = esize == 6'h10;
        if (is_elem)
        begin
            opc_ok = (issue.opc[5:2] & `OPC_ELEM_MASK) == `OPC_ELEM_FIXED
                     && issue.opc[0] == 1'b0;
        end
        else
        begin
            opc_ok = {issue.opc[5:2], 1'b0, issue.opc[0]} == `OPC_VEC_FIXED;
        end
        if (!rounding_mac_ext_present)
        begin
            opc_ok = 1'b0;
        end
        // any one of the three enables can withhold access
        enabled = access.os_simd_access_control && access.hyp_simd_trap_control
                  && access.secure_monitor_trap_control;
        if (is_h)
        begin
            index = {issue.idx_hi, issue.idx_lo, issue.idx_mid};
            m_hi  = 1'b0;
        end
        else
        begin
            index = {1'b0, issue.idx_hi, issue.idx_lo};
            m_hi  = issue.idx_mid;
        end
        if (is_elem)
        begin
            m_reg = {m_hi, issue.second_source_reg};
        end
        else
        begin
            // vector forms carry the register's top bit in the middle index field
            m_reg = {issue.idx_mid, issue.second_source_reg};
        end
        // indexed source: upper half invisible when the high index bit is clear
        if (issue.idx_hi)
        begin
            op2_view = ops.second_src;
        end
        else
        begin
            op2_view = {64'h0, ops.second_src[63:0]};
        end
        // lane counts: scalar one lane, else width over element size
        if (is_scalar)
        begin
            lanes_h = 4'h1;
            lanes_s = 3'h1;
        end
        else if (issue.wide)
        begin
            lanes_h = 4'h8;
            lanes_s = 3'h4;
        end
        else
        begin
            lanes_h = 4'h4;
            lanes_s = 3'h2;
        end
    end

    // read address stays unregistered: operands must meet the issue in its own cycle
    assign second_source_reg_num = m_reg;

    // ============================================================
    // per-lane datapath
    logic signed [15:0] elem_h;
    logic signed [31:0] elem_s;
    logic [127:0]       res_h;
    logic [127:0]       res_s;
    logic [7:0]         sat_h;
    logic [3:0]         sat_s;

    always_comb
    begin
        // one element picked per issue, shared by every lane
        elem_h = signed'(op2_view[16*index +: 16]);
        elem_s = signed'(op2_view[32*index[1:0] +: 32]);
    end

    genvar g;
    generate
        for (g = 0; g < `MAX_LANES; g++)
        begin : g_h
            logic signed [15:0] a;
            logic signed [15:0] b;
            logic signed [15:0] c;
            logic signed [34:0] acc;
            logic signed [18:0] hi;
            always_comb
            begin
                a = signed'(ops.first_src[16*g +: 16]);
                c = signed'(ops.dest_src[16*g +: 16]);
                if (is_elem)
                begin
                    b = elem_h;
                end
                else
                begin
                    b = signed'(ops.second_src[16*g +: 16]);
                end
                // 35 bits hold dest<<16 plus doubled 32-bit product exactly
                if (issue.subtract_operation)
                begin
                    acc = (35'(c) <<< 16) - (35'(a) * 35'(b) <<< 1);
                end
                else
                begin
                    acc = (35'(c) <<< 16) + (35'(a) * 35'(b) <<< 1);
                end
                // 19 bits cover the full swing of the shifted sum, so no wrap before saturating
                acc = acc + 35'(32'h00008000);
                hi  = acc[34:16];
                if (g >= lanes_h)
                begin
                    res_h[16*g +: 16] = 16'h0;
                    sat_h[g] = 1'b0;
                end
                else if (hi > 19'sd32767)
                begin
                    res_h[16*g +: 16] = 16'h7fff;
                    sat_h[g] = 1'b1;
                end
                else if (hi < -19'sd32768)
                begin
                    res_h[16*g +: 16] = 16'h8000;
                    sat_h[g] = 1'b1;
                end
                else
                begin
                    res_h[16*g +: 16] = hi[15:0];
                    sat_h[g] = 1'b0;
                end
            end
        end
        for (g = 0; g < `MAX_LANES / 2; g++)
        begin : g_s
            logic signed [31:0] a;
            logic signed [31:0] b;
            logic signed [31:0] c;
            logic signed [66:0] acc;
            logic signed [34:0] hi;
            always_comb
            begin
                a = signed'(ops.first_src[32*g +: 32]);
                c = signed'(ops.dest_src[32*g +: 32]);
                if (is_elem)
                begin
                    b = elem_s;
                end
                else
                begin
                    b = signed'(ops.second_src[32*g +: 32]);
                end
                // 67 bits hold dest<<32 plus doubled 64-bit product exactly
                if (issue.subtract_operation)
                begin
                    acc = (67'(c) <<< 32) - (67'(a) * 67'(b) <<< 1);
                end
                else
                begin
                    acc = (67'(c) <<< 32) + (67'(a) * 67'(b) <<< 1);
                end
                acc = acc + 67'(32'h80000000);
                hi  = acc[66:32];
                if (g >= lanes_s)
                begin
                    res_s[32*g +: 32] = 32'h0;
                    sat_s[g] = 1'b0;
                end
                else if (hi > 35'sd2147483647)
                begin
                    res_s[32*g +: 32] = 32'h7fffffff;
                    sat_s[g] = 1'b1;
                end
                else if (hi < -35'sd2147483648)
                begin
                    res_s[32*g +: 32] = 32'h80000000;
                    sat_s[g] = 1'b1;
                end
                else
                begin
                    res_s[32*g +: 32] = hi[31:0];
                    sat_s[g] = 1'b0;
                end
            end
        end
    endgenerate

    // ============================================================
    // state: result register and sticky flag
    core_state_t st_reg;
    core_state_t st_next;
    logic        exec;
    logic        any_sat;

    always_comb
    begin
        st_next = st_reg;
        exec    = issue.valid && enabled && size_ok && opc_ok;
        if (is_h)
        begin
            any_sat = |sat_h;
        end
        else
        begin
            any_sat = |sat_s;
        end
        st_next.res.done  = 1'b0;
        st_next.res.trap  = 1'b0;
        st_next.res.undef = 1'b0;
        // clear is software's path; a saturation in the same cycle still wins
        if (sat_flag_clear)
        begin
            st_next.sat_flag = 1'b0;
        end
        unique case (st_reg.state)
            ST_IDLE,
            ST_DONE:
            begin
                st_next.state = ST_IDLE;
                if (issue.valid)
                begin
                    st_next.state        = ST_DONE;
                    st_next.res.done     = 1'b1;
                    st_next.res.dest_reg = issue.dest_reg;
                    // undefined encodings outrank the access trap
                    if (!size_ok || !opc_ok)
                    begin
                        st_next.res.undef = 1'b1;
                    end
                    else if (!enabled)
                    begin
                        st_next.res.trap = 1'b1;
                    end
                    if (exec)
                    begin
                        if (is_h)
                        begin
                            st_next.res.data = res_h;
                        end
                        else
                        begin
                            st_next.res.data = res_s;
                        end
                        if (any_sat)
                        begin
                            st_next.sat_flag = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    // only the state struct resets; decode and lanes are pure logic
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= '{state: ST_IDLE, res: '0, sat_flag: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign result                     = st_reg.res;
    assign cumulative_saturation_flag = st_reg.sat_flag;

endmodule

// *** verification/sat_round_dbl_mac_high_half_properties.sv ***
/* port properties of the high-half multiply-accumulate datapath.
   assumes: bound to the top module; one clock, srst synchronous. */
`timescale 1ns/1ns
// ============================================================
// checker
module sat_round_dbl_mac_high_half_properties
    import rdmah_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire issue_t     issue,
    input wire operands_t  ops,
    input wire access_t    access,
    input wire logic       rounding_mac_ext_present,
    input wire logic       sat_flag_clear,
    input wire logic [4:0] second_source_reg_num,
    input wire result_t    result,
    input wire logic       cumulative_saturation_flag
);
    logic opc_ok;
    logic legal;
    assign opc_ok = issue.form[0] ? (&issue.opc[5:4] && issue.opc[2] && !issue.opc[0])
                                  : (issue.opc[5:2] == 4'h8 && issue.opc[0]);
    assign legal = issue.valid && rounding_mac_ext_present && opc_ok
                   && (issue.size == 2'h1 || issue.size == 2'h2);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    property p_exec;
        legal && (&access) |=> result.done && !result.undef && !result.trap;
    endproperty
    a_exec: assert property (p_exec) else $error("no clean result");
    property p_idle;
        !issue.valid |=> !result.done;
    endproperty
    a_idle: assert property (p_idle) else $error("done without issue");
    property p_resv;
        issue.valid && issue.size inside {2'h0, 2'h3} |=> result.undef && $stable(result.data);
    endproperty
    a_resv: assert property (p_resv) else $error("reserved size ran");
    property p_ext;
        issue.valid && !rounding_mac_ext_present |=> result.undef;
    endproperty
    a_ext: assert property (p_ext) else $error("absent extension ran");
    property p_trap;
        legal && !(&access) |=> result.trap && $stable(result.data);
    endproperty
    a_trap: assert property (p_trap) else $error("disabled access ran");
    property p_sticky;
        cumulative_saturation_flag && !sat_flag_clear |=> cumulative_saturation_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    property p_rm16;
        issue.form[0] && issue.size == 2'h1 |-> second_source_reg_num[4] == 1'h0;
    endproperty
    a_rm16: assert property (p_rm16) else $error("register top bit set");
    property p_zero;
        legal && (&access) && !issue.wide |=> result.data[127:64] == 64'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("upper half not zero");
    c_sat: cover property ($rose(cumulative_saturation_flag));
    c_undef: cover property (result.undef);
    c_trap: cover property (result.trap);
endmodule

// *** verification/simd_regfile_model.sv ***
/* far side: simd register file feeding the datapath and written back by it.
   assumes: the bench preloads registers through the load port. */
`timescale 1ns/1ns
// ============================================================
// register file
module simd_regfile_model
    import rdmah_pkg::*;
(
    input  wire logic         clk,
    input  wire issue_t       issue,
    input  wire logic [4:0]   rd_num,
    input  wire result_t      result,
    input  wire logic         ld_en,
    input  wire logic [4:0]   ld_idx,
    input  wire logic [127:0] ld_val,
    output operands_t         ops
);
    logic [127:0] regs [32];
    // reads are combinational: operands meet the issue in its own cycle
    assign ops.first_src = regs[issue.first_source_reg];
    assign ops.second_src = regs[rd_num];
    assign ops.dest_src = regs[issue.dest_reg];
    always @(posedge clk)
    begin
        if (ld_en)
            regs[ld_idx] <= ld_val;
        else if (result.done && !result.trap && !result.undef)
            regs[result.dest_reg] <= result.data;
    end
endmodule

// *** verification/sat_round_dbl_mac_high_half_tb_top.sv ***
/* self-checking bench for the high-half multiply-accumulate datapath.
   assumes: the register file model supplies operands; lane model below. */
`timescale 1ns/1ns
// ============================================================
// bench
module sat_round_dbl_mac_high_half_tb_top
    import rdmah_pkg::*;
;
    localparam logic [127:0] src_a = 128'h1234_8001_7fff_c000_0400_fff0_8000_7ffe;
    localparam logic [127:0] src_b = 128'h7fff_3c00_8000_0001_c001_2000_ffff_8000;
    localparam logic [127:0] src_d = 128'h0100_fff0_8000_7fff_0000_ffff_4000_c000;
    logic         clk = 1'h0, srst = 1'h1, ld_en = 1'h0, exp_flag = 1'h0;
    logic         sat_flag_clear = 1'h0, rounding_mac_ext_present = 1'h1;
    logic         cumulative_saturation_flag;
    logic [4:0]   ld_idx = 5'h0, second_source_reg_num;
    logic [127:0] ld_val = '0, last = '0;
    issue_t       issue = '0;
    access_t      access = 3'h7;
    operands_t    ops;
    result_t      result;
    int           fail_count = 0, n_compared = 0;
    always #2 clk = ~clk;
    sat_round_dbl_mac_high_half dut (.clk, .srst, .issue, .ops, .access,
        .rounding_mac_ext_present, .sat_flag_clear, .second_source_reg_num, .result,
        .cumulative_saturation_flag);
    simd_regfile_model rf (.clk, .issue, .rd_num(second_source_reg_num), .result, .ld_en,
        .ld_idx, .ld_val, .ops);
    task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic signed [67:0] sx(logic [127:0] v, int e, int es);
        return es == 16 ? 68'(signed'(v[e*16 +: 16])) : 68'(signed'(v[e*32 +: 32]));
    endfunction
    function automatic issue_t mk(form_t f, logic w, logic [1:0] sz, logic s, logic [2:0] h);
        return '{1'h1, f, w, sz, s, h[2], h[1], h[0],
                 f[0] ? {2'h3, s, 1'h1, h[2], 1'h0} : {4'h8, s, 1'h1}, 5'h1, 4'h3, 5'h2};
    endfunction
    task automatic ld(logic [4:0] idx, logic [127:0] v);
        ld_idx = idx;
        ld_val = v;
        ld_en = 1'h1;
        @(posedge clk);
        #1;
    endtask
    task automatic do_op(issue_t i, logic [127:0] a, b, d, logic u);
        logic [127:0] x;
        logic signed [67:0] acc, lim;
        logic [4:0] num;
        int es, k;
        logic ok;
        es = 8 << i.size;
        lim = (68'sh1 <<< (es - 1)) - 1;
        num = {i.idx_mid & !(i.form[0] && es == 16), i.second_source_reg};
        ok = !u && (&access);
        x = '0;
        for (int e = 0; ok && e < (i.form[1] ? 1 : (i.wide ? 128 : 64) / es); e++)
        begin
            k = !i.form[0] ? e : es == 16 ? {i.idx_hi, i.idx_lo, i.idx_mid} : {i.idx_hi, i.idx_lo};
            acc = (sx(d, e, es) <<< es) + (i.subtract_operation ? -2 : 2) * sx(a, e, es)
                  * sx(b, k, es) + (68'sh1 <<< (es - 1));
            acc = acc >>> es;
            exp_flag |= acc > lim || acc < -lim - 1;
            acc = acc > lim ? lim : acc < -lim - 1 ? -lim - 1 : acc;
            if (es == 16)
                x[e*16 +: 16] = acc[15:0];
            else
                x[e*32 +: 32] = acc[31:0];
        end
        ld(5'h1, a);
        ld(num, b);
        // the other half of the file holds the complement, so a bad index shows
        ld(num ^ 5'h10, ~b);
        ld(5'h2, d);
        ld_en = 1'h0;
        issue = i;
        @(posedge clk);
        #1;
        issue.valid = 1'h0;
        chk("undef", 128'(u), 128'(result.undef));
        chk("trap", 128'(!u && !(&access)), 128'(result.trap));
        if (ok)
            chk("done dest", 128'h22, 128'({result.done, result.dest_reg}));
        chk("data", ok ? x : last, result.data);
        chk("flag", 128'(exp_flag), 128'(cumulative_saturation_flag));
        last = ok ? x : last;
        @(posedge clk);
        #1;
        chk("writeback", ok ? x : d, rf.regs[2]);
    endtask
    task automatic t_lanes();
        for (int n = 0; n < 6; n++)
            do_op(mk(n[2] ? FORM_SCL_VEC : FORM_VEC_VEC, n[1], 2'h1 + n[0], n[0] ^ n[1], 3'h1),
                  src_a, src_b, src_d, 1'h0);
    endtask
    task automatic t_sat();
        do_op(mk(FORM_VEC_VEC, 1'h1, 2'h1, 1'h0, 3'h0), {8{16'h8000}}, {8{16'h8000}},
              {4{32'hffff_7fff}}, 1'h0);
        do_op(mk(FORM_VEC_VEC, 1'h1, 2'h2, 1'h1, 3'h0), {4{32'h8000_0000}},
              {4{32'h8000_0000}}, {4{32'h8000_0001}}, 1'h0);
        do_op(mk(FORM_VEC_VEC, 1'h0, 2'h1, 1'h0, 3'h0), '0, '0, '0, 1'h0);
        // clear held through the issue: the saturation must still win
        sat_flag_clear = 1'h1;
        exp_flag = 1'h0;
        do_op(mk(FORM_VEC_VEC, 1'h1, 2'h1, 1'h0, 3'h0), {8{16'h8000}}, {8{16'h8000}},
              {4{32'hffff_7fff}}, 1'h0);
        exp_flag = 1'h0;
        @(posedge clk);
        #1;
        sat_flag_clear = 1'h0;
        chk("flag clear", 128'h0, 128'(cumulative_saturation_flag));
    endtask
    task automatic t_elem();
        for (int n = 0; n < 16; n++)
            do_op(mk(n[1] ^ n[3] ? FORM_SCL_ELEM : FORM_VEC_ELEM, !n[2], 2'h1 + n[3], n[0],
                  n[2:0]), src_a, src_b, src_d, 1'h0);
    endtask
    task automatic t_refuse();
        issue_t i;
        i = mk(FORM_VEC_VEC, 1'h1, 2'h1, 1'h0, 3'h0);
        do_op(mk(FORM_VEC_VEC, 1'h1, 2'h0, 1'h0, 3'h0), src_a, src_b, src_d, 1'h1);
        do_op(mk(FORM_SCL_ELEM, 1'h1, 2'h3, 1'h1, 3'h5), src_a, src_b, src_d, 1'h1);
        i.opc[0] = 1'h0;
        do_op(i, src_a, src_b, src_d, 1'h1);
        i.opc[0] = 1'h1;
        rounding_mac_ext_present = 1'h0;
        do_op(i, src_a, src_b, src_d, 1'h1);
        rounding_mac_ext_present = 1'h1;
        for (int n = 0; n < 3; n++)
        begin
            access = ~(3'h1 << n);
            do_op(i, src_a, src_b, src_d, 1'h0);
        end
        do_op(mk(FORM_VEC_VEC, 1'h0, 2'h3, 1'h0, 3'h0), src_a, src_b, src_d, 1'h1);
        access = 3'h7;
    endtask
    initial
    begin
        #30000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        #1;
        srst = 1'h0;
        t_lanes();
        t_sat();
        t_elem();
        t_refuse();
        wrap_up();
    end
endmodule

bind sat_round_dbl_mac_high_half sat_round_dbl_mac_high_half_properties chk_i (.clk, .srst,
    .issue, .ops, .access, .rounding_mac_ext_present, .sat_flag_clear,
    .second_source_reg_num, .result, .cumulative_saturation_flag);
